//--- hw/acd_clock_mode_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module acd_clock_mode_ctrl (
    // Clock and reset
    input wire logic CORE_CLK,
    input wire logic RST,
    // Serial port and strap pins
    input wire logic SERIAL_SELECT_LOW,
    input wire logic SERIAL_CLOCK_FORMAT_STRAP,
    input wire logic SERIAL_DATA_STABILISER_STRAP_IN,
    output logic SERIAL_DATA_STABILISER_STRAP_OUT,
    output logic SERIAL_DATA_STABILISER_STRAP_OE,
    // Control pins
    input wire logic DIVIDER_SYNC,
    input wire logic POWER_DOWN_PIN,
    input wire logic DIFF_SELECT_PIN,
    input wire logic REDUCED_SWING_SELECT_PIN,
    // Clock conditioning status
    output logic SAMPLE_CLK,
    output logic STAB_ENABLED,
    output logic STAB_ACTIVE,
    // Operating mode
    output logic PIN_MODE,
    output logic POWER_DOWN,
    output logic STANDBY,
    output logic DRIVER_OE,
    output logic DIFF_MODE,
    output logic REDUCED_SWING,
    output logic [1:0] DATA_FORMAT
);
    // Assertion clock and reset
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (RST);

    logic [acd_pkg::NUM_PINS-1:0] pins_s;
    logic csb_s, sclk_s, sdio_s, sync_s, power_down_pin_s, diff_s, rs_s;

    // Pin synchroniser
    acd_pin_sync #(
        .W(acd_pkg::NUM_PINS),
        .RST_VAL(acd_pkg::PIN_RST)
    ) u_pins (
        .clk(CORE_CLK),
        .rst(RST),
        .d({REDUCED_SWING_SELECT_PIN, DIFF_SELECT_PIN, POWER_DOWN_PIN,
            DIVIDER_SYNC, SERIAL_DATA_STABILISER_STRAP_IN,
            SERIAL_CLOCK_FORMAT_STRAP, SERIAL_SELECT_LOW}),
        .q(pins_s)
    );

    // Named views of the filtered pins
    assign csb_s = pins_s[acd_pkg::PIN_CSB];
    assign sclk_s = pins_s[acd_pkg::PIN_SCLK];
    assign sdio_s = pins_s[acd_pkg::PIN_SDIO];
    assign sync_s = pins_s[acd_pkg::PIN_SYNC];
    assign power_down_pin_s = pins_s[acd_pkg::PIN_POWER_DOWN_PIN];
    assign diff_s = pins_s[acd_pkg::PIN_DIFF];
    assign rs_s = pins_s[acd_pkg::PIN_RS];

    // ---------------- Serial port ----------------
    acd_pkg::acd_phase_t phase_q, phase_d;
    logic [3:0] bitcnt_q, bitcnt_d;
    logic [15:0] shift_q, shift_d;
    logic rw_q, rw_d;
    logic [12:0] addr_q, addr_d;
    logic [7:0] rd_shift_q, rd_shift_d;
    logic sdo_q, sdo_d, sdo_oe_q, sdo_oe_d;
    logic sclk_prev_q;
    logic sclk_rise, sclk_fall;
    logic wr_en;
    logic [7:0] wr_data;
    logic [12:0] rd_addr;
    logic [7:0] rd_data;

    // Register file
    logic [7:0] power_q, power_d, stab_q, stab_d, div_q, div_d;
    logic [7:0] out_q, out_d, sync_ctl_q, sync_ctl_d;
    logic armed_q, armed_d;

    // Divider and stabiliser
    logic [3:0] ratio_q, ratio_d, cnt_q, cnt_d, high_len;
    logic div_clk_q, div_clk_d;
    logic [7:0] relock_q, relock_d;
    logic stab_en_q, stab_en_d, stab_act_q, stab_act_d;
    logic sync_prev_q, sync_apply, stab_en_now, rate_ok;
    logic [3:0] chk_cnt_q, chk_cnt_d;
    logic chk_ok_q, chk_ok_d, rise_next, disturb;

    // Mode outputs
    logic pin_mode_q, pin_mode_d, pd_q, pd_d, stby_q, stby_d;
    logic oe_q, oe_d, diff_q, diff_d, rs_q, rs_d;
    logic [1:0] fmt_q, fmt_d;

    assign sclk_rise = sclk_s & ~sclk_prev_q;
    assign sclk_fall = ~sclk_s & sclk_prev_q;

    // Address of the next byte to be read back
    always_comb begin
        if (phase_q == acd_pkg::PH_INSTR) begin
            rd_addr = {shift_q[11:0], sdio_s};
        end else begin
            rd_addr = addr_q + 13'h001;
        end
    end

    // Read multiplexer, unmapped reads as zero
    always_comb begin
        rd_data = 8'h00;
        if (rd_addr == acd_pkg::OFS_POWER) rd_data = power_q;
        if (rd_addr == acd_pkg::OFS_STAB) rd_data = stab_q;
        if (rd_addr == acd_pkg::OFS_DIV) rd_data = div_q;
        if (rd_addr == acd_pkg::OFS_OUT) rd_data = out_q;
        if (rd_addr == acd_pkg::OFS_SYNC) rd_data = sync_ctl_q;
        if (rd_addr == acd_pkg::OFS_STATUS) begin
            rd_data = {4'h0, armed_q, pin_mode_q, stab_act_q, stab_en_q};
        end
    end

    // Frame sequencer: instruction, then data bytes with rising address
    always_comb begin
        phase_d = phase_q;
        bitcnt_d = bitcnt_q;
        shift_d = shift_q;
        rw_d = rw_q;
        addr_d = addr_q;
        rd_shift_d = rd_shift_q;
        sdo_d = sdo_q;
        sdo_oe_d = sdo_oe_q;
        wr_en = 1'b0;
        wr_data = {shift_q[6:0], sdio_s};
        if (csb_s) begin
            phase_d = acd_pkg::PH_INSTR;
            bitcnt_d = 4'h0;
            sdo_oe_d = 1'b0;
        end else begin
            if (sclk_rise) begin
                shift_d = {shift_q[14:0], sdio_s};
                unique case (phase_q)
                    acd_pkg::PH_INSTR: begin
                        if (bitcnt_q == 4'(acd_pkg::INSTR_BITS - 1)) begin
                            rw_d = shift_q[14];
                            addr_d = rd_addr;
                            rd_shift_d = rd_data;
                            phase_d = acd_pkg::PH_DATA;
                            bitcnt_d = 4'h0;
                        end else begin
                            bitcnt_d = bitcnt_q + 4'h1;
                        end
                    end
                    acd_pkg::PH_DATA: begin
                        if (bitcnt_q == 4'(acd_pkg::DATA_BITS - 1)) begin
                            wr_en = ~rw_q;
                            addr_d = rd_addr;
                            rd_shift_d = rd_data;
                            bitcnt_d = 4'h0;
                        end else begin
                            bitcnt_d = bitcnt_q + 4'h1;
                        end
                    end
                endcase
            end
            // Read data leaves on the falling serial clock edge
            if (sclk_fall && phase_q == acd_pkg::PH_DATA && rw_q) begin
                sdo_oe_d = 1'b1;
                sdo_d = rd_shift_q[7];
                rd_shift_d = {rd_shift_q[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            phase_q <= acd_pkg::PH_INSTR;
            bitcnt_q <= 4'h0;
            shift_q <= 16'h0000;
            rw_q <= 1'b0;
            addr_q <= 13'h0000;
            rd_shift_q <= 8'h00;
            sdo_q <= 1'b0;
            sdo_oe_q <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            bitcnt_q <= bitcnt_d;
            shift_q <= shift_d;
            rw_q <= rw_d;
            addr_q <= addr_d;
            rd_shift_q <= rd_shift_d;
            sdo_q <= sdo_d;
            sdo_oe_q <= sdo_oe_d;
            sclk_prev_q <= sclk_s;
        end
    end

    // ---------------- Registers ----------------
    always_comb begin
        power_d = power_q;
        stab_d = stab_q;
        div_d = div_q;
        out_d = out_q;
        sync_ctl_d = sync_ctl_q;
        armed_d = armed_q;
        if (sync_apply && sync_ctl_q[acd_pkg::SYNC_FIRST_BIT]) begin
            armed_d = 1'b0;
        end
        if (wr_en) begin
            if (addr_q == acd_pkg::OFS_POWER) power_d = wr_data;
            if (addr_q == acd_pkg::OFS_STAB) stab_d = wr_data;
            if (addr_q == acd_pkg::OFS_DIV) div_d = wr_data;
            if (addr_q == acd_pkg::OFS_OUT) out_d = wr_data;
            if (addr_q == acd_pkg::OFS_SYNC) begin
                sync_ctl_d = wr_data;
                armed_d = 1'b1;
            end
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            power_q <= acd_pkg::RST_POWER;
            stab_q <= acd_pkg::RST_STAB;
            div_q <= acd_pkg::RST_DIV;
            out_q <= acd_pkg::RST_OUT;
            sync_ctl_q <= acd_pkg::RST_SYNC;
            armed_q <= 1'b0;
        end else begin
            power_q <= power_d;
            stab_q <= stab_d;
            div_q <= div_d;
            out_q <= out_d;
            sync_ctl_q <= sync_ctl_d;
            armed_q <= armed_d;
        end
    end

    // ---------------- Divider and stabiliser ----------------
    // valid sync pulse
    assign sync_apply = sync_s & ~sync_prev_q
        & sync_ctl_q[acd_pkg::SYNC_EN_BIT]
        & (~sync_ctl_q[acd_pkg::SYNC_FIRST_BIT] | armed_q);
    assign stab_en_now = pin_mode_q ? sdio_s : stab_q[acd_pkg::STAB_EN_BIT];
    assign rate_ok = ratio_q <= 4'(acd_pkg::DIV_MAX_LOCK);
    assign high_len = stab_act_q ? (ratio_q >> 1) : ((ratio_q + 4'h1) >> 1);
    assign rise_next = div_clk_d & ~div_clk_q;
    assign disturb = pd_q | sync_apply | (ratio_d != ratio_q);

    always_comb begin
        ratio_d = div_q[3:0];
        if (div_q[3:0] < acd_pkg::DIV_MIN) ratio_d = acd_pkg::DIV_MIN;
        if (div_q > {4'h0, acd_pkg::DIV_MAX}) ratio_d = acd_pkg::DIV_MAX;
        if (disturb) begin
            cnt_d = 4'h0;
        end else if (cnt_q == ratio_q - 4'h1) begin
            cnt_d = 4'h0;
        end else begin
            cnt_d = cnt_q + 4'h1;
        end
        // Low in the same cycle that power-down is registered
        div_clk_d = ~pd_d & (cnt_d < high_len);
        stab_en_d = stab_en_now;
        if ((ratio_d != ratio_q) || !stab_en_now || pd_q) begin
            relock_d = 8'(acd_pkg::RELOCK_CYC);
        end else if (relock_q != 8'h00) begin
            relock_d = relock_q - 8'h01;
        end else begin
            relock_d = relock_q;
        end
        // Next count, so a reload bypasses the loop at once
        stab_act_d = stab_en_now & rate_ok & (relock_d == 8'h00);
        // Period checker helper
        chk_cnt_d = rise_next ? 4'h1 : chk_cnt_q + 4'h1;
        chk_ok_d = disturb ? 1'b0 : (rise_next | chk_ok_q);
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            ratio_q <= acd_pkg::RST_DIV[3:0];
            cnt_q <= 4'h0;
            div_clk_q <= 1'b0;
            relock_q <= 8'(acd_pkg::RELOCK_CYC);
            stab_en_q <= 1'b0;
            stab_act_q <= 1'b0;
            sync_prev_q <= 1'b0;
            chk_cnt_q <= 4'h0;
            chk_ok_q <= 1'b0;
        end else begin
            ratio_q <= ratio_d;
            cnt_q <= cnt_d;
            div_clk_q <= div_clk_d;
            relock_q <= relock_d;
            stab_en_q <= stab_en_d;
            stab_act_q <= stab_act_d;
            sync_prev_q <= sync_s;
            chk_cnt_q <= chk_cnt_d;
            chk_ok_q <= chk_ok_d;
        end
    end

    // ---------------- Operating mode ----------------
    always_comb begin
        logic [1:0] pmode;
        logic pin_stby;
        pmode = power_q[acd_pkg::PWR_MODE_LSB +: 2];
        pin_stby = power_q[acd_pkg::PWR_PIN_STBY_BIT];
        // serial mode persists once select goes low
        pin_mode_d = pin_mode_q & csb_s;
        pd_d = pin_mode_q ? power_down_pin_s
            : ((pmode == acd_pkg::PWR_DOWN) | (power_down_pin_s & ~pin_stby));
        stby_d = ~pin_mode_q & ~pd_d
            & ((pmode == acd_pkg::PWR_STBY) | (power_down_pin_s & pin_stby));
        oe_d = ~pd_d & ~stby_d;
        diff_d = diff_s | (~pin_mode_q & out_q[acd_pkg::OUT_DIFF_BIT]);
        rs_d = diff_d & (rs_s | (~pin_mode_q & out_q[acd_pkg::OUT_RS_BIT]));
        if (pin_mode_q) begin
            fmt_d = sclk_s ? acd_pkg::FMT_TWOS : acd_pkg::FMT_OFFSET;
        end else if (out_q[acd_pkg::OUT_FMT_LSB +: 2] > acd_pkg::FMT_GRAY) begin
            fmt_d = acd_pkg::FMT_OFFSET;
        end else begin
            fmt_d = out_q[acd_pkg::OUT_FMT_LSB +: 2];
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            pin_mode_q <= 1'b1;
            pd_q <= 1'b0;
            stby_q <= 1'b0;
            oe_q <= 1'b0;
            diff_q <= 1'b0;
            rs_q <= 1'b0;
            fmt_q <= acd_pkg::FMT_OFFSET;
        end else begin
            pin_mode_q <= pin_mode_d;
            pd_q <= pd_d;
            stby_q <= stby_d;
            oe_q <= oe_d;
            diff_q <= diff_d;
            rs_q <= rs_d;
            fmt_q <= fmt_d;
        end
    end

    // Outputs straight from flops
    assign SERIAL_DATA_STABILISER_STRAP_OUT = sdo_q;
    assign SERIAL_DATA_STABILISER_STRAP_OE = sdo_oe_q;
    assign SAMPLE_CLK = div_clk_q;
    assign STAB_ENABLED = stab_en_q;
    assign STAB_ACTIVE = stab_act_q;
    assign PIN_MODE = pin_mode_q;
    assign POWER_DOWN = pd_q;
    assign STANDBY = stby_q;
    assign DRIVER_OE = oe_q;
    assign DIFF_MODE = diff_q;
    assign REDUCED_SWING = rs_q;
    assign DATA_FORMAT = fmt_q;

    // Checks
    a_div_period: assert property (
        rise_next && chk_ok_q && !disturb |-> chk_cnt_q == ratio_q)
        else $error("divided clock period differs from ratio");
    a_ratio_range: assert property (
        ratio_q >= acd_pkg::DIV_MIN && ratio_q <= acd_pkg::DIV_MAX)
        else $error("divide ratio out of range");
    a_sync_restart: assert property (
        sync_apply && !pd_q |=> cnt_q == 4'h0 ##1 cnt_q == 4'h1)
        else $error("sync did not restart divider");
    a_first_only_disarm: assert property (
        sync_apply && sync_ctl_q[acd_pkg::SYNC_FIRST_BIT] && !wr_en
        |=> !armed_q)
        else $error("first-only sync left armed");
    a_relock_bypass: assert property (
        ratio_d != ratio_q |=> !stab_act_q [*8])
        else $error("stabiliser active during relock");
    a_low_rate_off: assert property (
        ratio_q > 4'(acd_pkg::DIV_MAX_LOCK) |=> !stab_act_q)
        else $error("stabiliser active below minimum rate");
    a_pin_strap_stab: assert property (
        pin_mode_q |=> stab_en_q == $past(sdio_s))
        else $error("stabiliser not following strap");
    a_power_down_pin_hiz: assert property (
        pd_q |-> !oe_q && !div_clk_q)
        else $error("drivers enabled during power-down");
    a_serial_persist: assert property (
        !pin_mode_q |=> !pin_mode_q)
        else $error("serial mode reverted to pin mode");
    a_swing_needs_diff: assert property (
        rs_q |-> diff_q)
        else $error("reduced swing outside differential mode");
    a_pin_format: assert property (
        pin_mode_q && pin_mode_d |=> fmt_q == {1'b0, $past(sclk_s)})
        else $error("pin format not following strap");
endmodule : acd_clock_mode_ctrl
`default_nettype wire

//--- hw/acd_pkg.sv
// What this block does
// - Sample clock divided by an integer ratio from 2 to 8.
// - Sync control bits choose resync on every sync or first only.
// - A valid sync pulse returns the divider counter to its start.
// - Stabiliser regenerates the falling edge for a near 50% clock.
// - Stabiliser loop stays off when the divided rate is below 20 MHz.
// - After a rate change the loop is bypassed for 1.5 us relock.
// - In pin mode the data strap high enables the stabiliser.
// - In serial mode stabiliser is on after reset; writing 0x00 disables.
// - Power-down by pin or serial command; drivers go high impedance.
// - Serial control offers standby, keeping the reference powered.
// - A serial setting makes the power-down pin enter standby instead.
// - Drivers start single-ended; pin or serial bit selects differential.
// - Differential mode uses reduced swing by pin or serial setting.
// - In pin mode the clock strap picks offset binary or twos complement.
// - Serial control picks offset binary, twos complement or Gray.
// - Select high at power-up means pin mode; once low, serial persists.
package acd_pkg;
    // Clock and timing
    localparam int CLK_MHZ = 100;
    localparam int STAB_MIN_MHZ = 20;
    localparam int RELOCK_NS = 1500;
    localparam int RELOCK_CYC = (RELOCK_NS * CLK_MHZ + 999) / 1000;
    localparam int DIV_MAX_LOCK = CLK_MHZ / STAB_MIN_MHZ;
    localparam logic [3:0] DIV_MIN = 4'h2;
    localparam logic [3:0] DIV_MAX = 4'h8;
    // Serial frame
    localparam int INSTR_BITS = 16;
    localparam int DATA_BITS = 8;
    localparam int ADDR_W = 13;
    // Register offsets
    localparam logic [12:0] OFS_POWER = 13'h008;
    localparam logic [12:0] OFS_STAB = 13'h009;
    localparam logic [12:0] OFS_DIV = 13'h00b;
    localparam logic [12:0] OFS_STATUS = 13'h00f;
    localparam logic [12:0] OFS_OUT = 13'h014;
    localparam logic [12:0] OFS_SYNC = 13'h100;
    // Values after reset
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_STAB = 8'h01;
    localparam logic [7:0] RST_DIV = 8'h02;
    localparam logic [7:0] RST_OUT = 8'h00;
    localparam logic [7:0] RST_SYNC = 8'h00;
    // Field positions
    localparam int STAB_EN_BIT = 0;
    localparam int SYNC_EN_BIT = 1;
    localparam int SYNC_FIRST_BIT = 2;
    localparam int PWR_MODE_LSB = 0;
    localparam int PWR_PIN_STBY_BIT = 2;
    localparam int OUT_FMT_LSB = 0;
    localparam int OUT_DIFF_BIT = 2;
    localparam int OUT_RS_BIT = 3;
    // Field codes
    localparam logic [1:0] PWR_DOWN = 2'h1;
    localparam logic [1:0] PWR_STBY = 2'h2;
    localparam logic [1:0] FMT_OFFSET = 2'h0;
    localparam logic [1:0] FMT_TWOS = 2'h1;
    localparam logic [1:0] FMT_GRAY = 2'h2;
    // Synchronised pin vector
    localparam int PIN_CSB = 0;
    localparam int PIN_SCLK = 1;
    localparam int PIN_SDIO = 2;
    localparam int PIN_SYNC = 3;
    localparam int PIN_POWER_DOWN_PIN = 4;
    localparam int PIN_DIFF = 5;
    localparam int PIN_RS = 6;
    localparam int NUM_PINS = 7;
    localparam logic [6:0] PIN_RST = 7'h01;
    // Serial frame phase
    typedef enum logic {PH_INSTR, PH_DATA} acd_phase_t;
endpackage : acd_pkg

//--- hw/acd_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module acd_pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Raw pins and filtered levels
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;
    logic [W-1:0] out_d;

    // Filtered level follows once stages two and three agree
    always_comb begin
        out_d = out_q;
        for (int i = 0; i < W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                out_d[i] = s3_q[i];
            end
        end
    end

    // Three-stage chain
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            out_q <= RST_VAL;
        end else begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign q = out_q;
endmodule : acd_pin_sync
`default_nettype wire

//--- verification/acd_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module acd_host_model (
    // Core clock for pacing
    input wire logic clk,
    // Serial lines and straps
    output logic sel_n,
    output logic sck,
    output logic sdo,
    input wire logic sdi,
    // Divider sync source
    output logic sync
);
    initial begin
        sel_n = 1'b1;
        sck = 1'b0;
        sdo = 1'b0;
        sync = 1'b0;
    end

    // One serial clock phase of 8 core cycles
    task automatic half(input logic v);
        sck = v;
        repeat (8) @(posedge clk);
        #1;
    endtask : half

    task automatic xfer(input logic [15:0] ins, input logic [7:0] wd,
                        output logic [7:0] rd);
        sel_n = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            // Released line shows the inverse of its last value
            sdo = (i > 7) ? ins[i-8] : (ins[15] ? ~sdo : wd[i]);
            half(1'b0);
            if (i < 8) begin
                rd[i] = sdi;
            end
            half(1'b1);
        end
        half(1'b0);
        sel_n = 1'b1;
        repeat (8) @(posedge clk);
        #1;
    endtask : xfer
endmodule : acd_host_model
`default_nettype wire

//--- verification/adc_clock_divider_mode_control_bench.sv
`timescale 1ns/100ps
`default_nettype none
module adc_clock_divider_mode_control_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic power_down_pin = 1'b0;
    logic diff = 1'b0;
    logic rs = 1'b0;
    logic sel_n, sck, hsd, sync, dout, doe, samp, s_en, s_act;
    logic pin, pdn, stby, doe2, dm, rsw;
    logic [1:0] fmt;
    logic [7:0] v;
    int err_count = 0;
    int samples_checked = 0;
    int d, e, h, n;
    // Shared data pin level
    wire logic sdio = doe ? dout : hsd;

    // Clock
    always #5 clk = ~clk;

    acd_host_model acd_host_model_inst (.clk(clk), .sel_n(sel_n),
        .sck(sck), .sdo(hsd), .sdi(sdio), .sync(sync));

    acd_clock_mode_ctrl acd_clock_mode_ctrl_inst (.CORE_CLK(clk),
        .RST(rst), .SERIAL_SELECT_LOW(sel_n),
        .SERIAL_CLOCK_FORMAT_STRAP(sck),
        .SERIAL_DATA_STABILISER_STRAP_IN(sdio),
        .SERIAL_DATA_STABILISER_STRAP_OUT(dout),
        .SERIAL_DATA_STABILISER_STRAP_OE(doe), .DIVIDER_SYNC(sync),
        .POWER_DOWN_PIN(power_down_pin), .DIFF_SELECT_PIN(diff),
        .REDUCED_SWING_SELECT_PIN(rs), .SAMPLE_CLK(samp),
        .STAB_ENABLED(s_en), .STAB_ACTIVE(s_act), .PIN_MODE(pin),
        .POWER_DOWN(pdn), .STANDBY(stby), .DRIVER_OE(doe2),
        .DIFF_MODE(dm), .REDUCED_SWING(rsw), .DATA_FORMAT(fmt));

    // Compare and count
    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : cyc

    task automatic wr(input logic [12:0] a, input logic [7:0] wd);
        acd_host_model_inst.xfer({3'h0, a}, wd, v);
    endtask : wr

    task automatic rd(input logic [12:0] a, input logic [7:0] x);
        acd_host_model_inst.xfer({3'h4, a}, 8'h00, v);
        chk("read", v, x);
    endtask : rd

    // Cycles to next divided rise, with high cycles seen
    task automatic to_rise(output int k, output int hi);
        logic p;
        k = 0;
        hi = int'(samp);
        p = samp;
        while (k < 400) begin
            cyc(1);
            k++;
            if (samp && !p) begin
                return;
            end
            hi += int'(samp);
            p = samp;
        end
        err_count++;
        complete_run();
    endtask : to_rise

    task automatic sync_lat(output int k);
        acd_host_model_inst.sync = 1'b1;
        to_rise(k, h);
        acd_host_model_inst.sync = 1'b0;
    endtask : sync_lat

    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    initial begin
        cyc(2);
        rst = 1'b0;
        cyc(8);
        chk("pin_mode", pin, 1'b1);
        // Straps low then high in pin mode
        for (int i = 0; i < 2; i++) begin
            acd_host_model_inst.sck = i[0];
            acd_host_model_inst.sdo = i[0];
            {diff, rs, power_down_pin} = {3{i[0]}};
            cyc(8);
            chk("format", fmt, {1'b0, i[0]});
            chk("stab", s_en, i[0]);
            chk("diff", dm, i[0]);
            chk("swing", rsw, i[0]);
            chk("pdown", pdn, i[0]);
            chk("drv_oe", doe2, !i[0]);
        end
        acd_host_model_inst.sck = 1'b0;
        {diff, rs, power_down_pin} = 3'h0;
        cyc(8);
        $display("test pins done");
        rd(13'h009, 8'h01);
        chk("pin_mode", pin, 1'b0);
        chk("stab", s_en, 1'b1);
        wr(13'h009, 8'h00);
        chk("stab", s_en, 1'b0);
        rd(13'h0aa, 8'h00);
        // Stabiliser off for every ratio; input clock is 50%
        for (int r = 2; r <= 8; r++) begin
            wr(13'h00b, r[7:0]);
            to_rise(n, h);
            to_rise(n, h);
            chk("period", n[7:0], r[7:0]);
            chk("high", h[7:0], 8'((r + 1) / 2));
        end
        $display("test divider done");
        for (int f = 0; f < 3; f++) begin
            wr(13'h014, f[7:0]);
            chk("format", fmt, f[1:0]);
        end
        wr(13'h014, 8'h0c);
        chk("diff", dm, 1'b1);
        chk("swing", rsw, 1'b1);
        wr(13'h014, 8'h00);
        wr(13'h008, 8'h01);
        chk("pdown", pdn, 1'b1);
        chk("drv_oe", doe2, 1'b0);
        wr(13'h008, 8'h02);
        chk("stby", stby, 1'b1);
        chk("pdown", pdn, 1'b0);
        wr(13'h008, 8'h04);
        power_down_pin = 1'b1;
        cyc(8);
        chk("stby", stby, 1'b1);
        chk("pdown", pdn, 1'b0);
        power_down_pin = 1'b0;
        cyc(8);
        chk("drv_oe", doe2, 1'b1);
        $display("test modes done");
        wr(13'h009, 8'h01);
        wr(13'h00b, 8'h05);
        chk("active", s_act, 1'b0);
        cyc(150);
        chk("active", s_act, 1'b1);
        to_rise(n, h);
        to_rise(n, h);
        chk("high", h[7:0], 8'h02);
        wr(13'h00b, 8'h08);
        cyc(170);
        chk("active", s_act, 1'b0);
        $display("test stabiliser done");
        // Each sync starts in the high phase, 0 to 3 cycles after a rise
        wr(13'h100, 8'h02);
        to_rise(n, h);
        sync_lat(d);
        chk("sync", d[7:0], 8'h05);
        cyc(11);
        sync_lat(e);
        chk("sync", e[7:0], d[7:0]);
        wr(13'h100, 8'h06);
        to_rise(n, h);
        sync_lat(d);
        chk("sync", d[7:0], 8'h05);
        cyc(9);
        sync_lat(e);
        chk("sync", e[7:0], 8'h07);
        wr(13'h100, 8'h06);
        to_rise(n, h);
        sync_lat(e);
        chk("sync", e[7:0], 8'h05);
        $display("test sync done");
        complete_run();
    end
endmodule : adc_clock_divider_mode_control_bench
`default_nettype wire
